// file: common/psp_pkg.sv
/*
 * Shared constants for the configuration loader: scan instruction codes,
 * register lengths and the power-up reset timing.
 * Assumes a single 25 MHz system clock samples the scan pins.
 */
package psp_pkg;
    // Instruction register length and codes
    localparam int          IR_LEN        = 8;
    localparam logic [7:0]  OP_EXTEST     = 8'h00;
    localparam logic [7:0]  OP_SAMPLE     = 8'h01;
    localparam logic [7:0]  OP_IDCODE     = 8'h16;
    localparam logic [7:0]  OP_SCAN_USER_CODE   = 8'h17;
    localparam logic [7:0]  OP_PROG_EN    = 8'h15;
    localparam logic [7:0]  OP_ERASE      = 8'h03;
    localparam logic [7:0]  OP_PROGRAM    = 8'h07;
    localparam logic [7:0]  OP_READ       = 8'h0A;
    localparam logic [7:0]  OP_SECURE     = 8'h09;
    localparam logic [7:0]  OP_PROG_UC    = 8'h1A;
    localparam logic [7:0]  OP_PROG_DIS   = 8'h1E;
    localparam logic [7:0]  OP_BYPASS     = 8'hFF;
    // Capture pattern of the instruction register
    localparam logic [7:0]  IR_CAPTURE    = 8'h1D;
    // Register widths
    localparam int          SIG_LEN       = 32;
    localparam int          CFG_LEN       = 64;
    localparam int          BSR_LEN       = 16;
    // Power-up reset time in ns and derived cycles
    localparam int          CLK_NS        = 40;
    localparam int          T_POR_NS      = 1000;
    localparam int          POR_CYC       = (T_POR_NS + CLK_NS - 1) / CLK_NS;
    // Arbitrary neutral identity value
    localparam logic [31:0] IDCODE_VAL    = 32'h0000_1001;
endpackage

// file: logic/psp_loader.sv
/*
 * Scan port with boundary cells, in-system programming of a configuration
 * array, security lock with erase-only clear, user signature and power-up
 * reset. Assumes tck/tms/tdi arrive asynchronously and are sampled by clk;
 * the nonvolatile cells sit outside and are loaded through nv_* ports.
 */
// How it works
// - Standard scan state machine drives the port
// - Boundary cells capture pins, apply shifted data
// - Programming instructions ride the same scan port
// - Enable, erase, program, read, disable sequence
// - Lock set makes readback shift zeros
// - Lock set blocks program and verify
// - Only full erase clears lock bit
// - Power-up holds registers low for reset time
// - Pull-ups enabled until configuration active
// - User signature readable regardless of lock
`timescale 1ns/1ps
module psp_loader #(
    parameter int CFG_W = psp_pkg::CFG_LEN,   // Configuration array bits
    parameter int BSR_W = psp_pkg::BSR_LEN    // Boundary cells
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Scan port pins
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    output logic                  tdo,
    output logic                  tdo_oe,
    // Boundary pins
    input  wire logic [BSR_W-1:0] pin_in,
    output logic [BSR_W-1:0]      pin_test_out,
    output logic                  pin_test_en,
    // Power-up and pin structure
    output logic                  por_busy,
    output logic                  pull_up_en,
    output logic                  reg_q_clr,
    // Nonvolatile image
    input  wire logic             nv_lock,
    input  wire logic [31:0]      nv_sig,
    input  wire logic [CFG_W-1:0] nv_cfg,
    output logic                  nv_wr,
    output logic                  nv_lock_nxt,
    output logic [31:0]           nv_sig_nxt,
    output logic [CFG_W-1:0]      nv_cfg_nxt,
    // Active configuration and lock copy
    output logic [CFG_W-1:0]      cfg_out,
    output logic                  lock_out
);
    // Widths the shift path and its 6-bit length field can serve
    if (CFG_W < 8 || CFG_W > 64 || BSR_W < 1 || BSR_W > 32)
        $error("psp_loader: unsupported widths");

    // Scan controller states, Gray along the usual path
    typedef enum logic [3:0] {
        S_RESET = 4'h0, S_IDLE = 4'h1, S_SELDR = 4'h3, S_CAPDR = 4'h2,
        S_SHDR  = 4'h6, S_EX1DR = 4'h7, S_PAUDR = 4'h5, S_EX2DR = 4'h4,
        S_UPDR  = 4'hC, S_SELIR = 4'hD, S_CAPIR = 4'hF, S_SHIR = 4'hE,
        S_EX1IR = 4'hA, S_PAUIR = 4'hB, S_EX2IR = 4'h9, S_UPIR = 4'h8
    } psp_state_t;

    // Pin synchronisers
    logic [2:0] s1_r, s2_r;           // First and second stages
    logic       tck_d_r;              // Previous tck for edge find
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            s1_r    <= 3'h0;
            s2_r    <= 3'h0;
            tck_d_r <= 1'b0;
        end
        else
        begin
            s1_r    <= {tck, tms, tdi};
            s2_r    <= s1_r;
            tck_d_r <= s2_r[2];
        end
    logic rise, fall;                 // tck edges
    assign rise = s2_r[2] & ~tck_d_r;
    assign fall = ~s2_r[2] & tck_d_r;
    logic tms_s, tdi_s;               // Synchronised pins
    assign tms_s = s2_r[1];
    assign tdi_s = s2_r[0];

    // Power-up reset counter
    logic [$clog2(psp_pkg::POR_CYC+1)-1:0] por_cnt_r;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            por_cnt_r <= '0;
        else if (por_cnt_r != ($bits(por_cnt_r))'(psp_pkg::POR_CYC))
            por_cnt_r <= por_cnt_r + 1'b1;
    logic por_done;
    assign por_done = (por_cnt_r == ($bits(por_cnt_r))'(psp_pkg::POR_CYC));

    // Power-up outputs: registers cleared, pull-ups on until active
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            por_busy   <= 1'b1;
            reg_q_clr  <= 1'b1;
            pull_up_en <= 1'b1;
        end
        else
        begin
            por_busy   <= ~por_done;
            reg_q_clr  <= ~por_done;
            pull_up_en <= ~por_done;
        end

    // Scan controller, stepped on tck rise
    psp_state_t st_r, st_nxt;
    always_comb
        case (st_r)
            S_RESET: st_nxt = tms_s ? S_RESET : S_IDLE;
            S_IDLE:  st_nxt = tms_s ? S_SELDR : S_IDLE;
            S_SELDR: st_nxt = tms_s ? S_SELIR : S_CAPDR;
            S_CAPDR: st_nxt = tms_s ? S_EX1DR : S_SHDR;
            S_SHDR:  st_nxt = tms_s ? S_EX1DR : S_SHDR;
            S_EX1DR: st_nxt = tms_s ? S_UPDR  : S_PAUDR;
            S_PAUDR: st_nxt = tms_s ? S_EX2DR : S_PAUDR;
            S_EX2DR: st_nxt = tms_s ? S_UPDR  : S_SHDR;
            S_UPDR:  st_nxt = tms_s ? S_SELDR : S_IDLE;
            S_SELIR: st_nxt = tms_s ? S_RESET : S_CAPIR;
            S_CAPIR: st_nxt = tms_s ? S_EX1IR : S_SHIR;
            S_SHIR:  st_nxt = tms_s ? S_EX1IR : S_SHIR;
            S_EX1IR: st_nxt = tms_s ? S_UPIR  : S_PAUIR;
            S_PAUIR: st_nxt = tms_s ? S_EX2IR : S_PAUIR;
            S_EX2IR: st_nxt = tms_s ? S_UPIR  : S_SHIR;
            S_UPIR:  st_nxt = tms_s ? S_SELDR : S_IDLE;
            default: st_nxt = S_RESET;
        endcase
    always_ff @(posedge clk or posedge rst)
        if (rst)
            st_r <= S_RESET;
        else if (!por_done)
            st_r <= S_RESET;
        else if (rise)
            st_r <= st_nxt;

    // Instruction register
    logic [7:0] ir_sh_r, ir_r;
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            ir_sh_r <= 8'h00;
            ir_r    <= psp_pkg::OP_IDCODE;
        end
        else if (st_r == S_RESET)
            ir_r <= psp_pkg::OP_IDCODE;
        else if (rise)
            case (st_r)
                S_CAPIR: ir_sh_r <= psp_pkg::IR_CAPTURE;
                S_SHIR:  ir_sh_r <= {tdi_s, ir_sh_r[7:1]};
                default: ir_sh_r <= ir_sh_r;
            endcase
        else if (fall && st_r == S_UPIR)
            ir_r <= ir_sh_r;

    // Programming mode flag
    logic prog_r;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            prog_r <= 1'b0;
        else if (st_r == S_RESET)
            prog_r <= 1'b0;
        else if (fall && st_r == S_UPIR && ir_sh_r == psp_pkg::OP_PROG_EN)
            prog_r <= 1'b1;
        else if (fall && st_r == S_UPIR && ir_sh_r == psp_pkg::OP_PROG_DIS)
            prog_r <= 1'b0;

    // Data shift register, widest path sized
    localparam int DW = (CFG_W > 32) ? CFG_W : 32;
    logic [DW-1:0] dr_r;
    logic [5:0]    dlen;              // Last bit index of selected path
    always_comb
        case (ir_r)
            psp_pkg::OP_EXTEST, psp_pkg::OP_SAMPLE: dlen = 6'(BSR_W-1);
            psp_pkg::OP_IDCODE, psp_pkg::OP_SCAN_USER_CODE,
            psp_pkg::OP_PROG_UC:                    dlen = 6'd31;
            psp_pkg::OP_PROGRAM, psp_pkg::OP_READ:  dlen = 6'(CFG_W-1);
            default:                                dlen = 6'd0;
        endcase

    // Capture value for the selected path
    logic [DW-1:0] cap;
    always_comb
    begin
        cap = '0;
        case (ir_r)
            psp_pkg::OP_EXTEST, psp_pkg::OP_SAMPLE: cap[BSR_W-1:0] = pin_in;
            psp_pkg::OP_IDCODE:   cap[31:0] = psp_pkg::IDCODE_VAL;
            psp_pkg::OP_SCAN_USER_CODE: cap[31:0] = nv_sig;
            psp_pkg::OP_READ:
                if (prog_r && !nv_lock)
                    cap[CFG_W-1:0] = nv_cfg;
            default:              cap = '0;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
        if (rst)
            dr_r <= '0;
        else if (rise && st_r == S_CAPDR)
            dr_r <= cap;
        else if (rise && st_r == S_SHDR)
        begin
            dr_r       <= dr_r >> 1;
            dr_r[dlen] <= tdi_s;
        end

    // Boundary output cells, driven under extest
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            pin_test_out <= '0;
            pin_test_en  <= 1'b0;
        end
        else
        begin
            pin_test_en <= (ir_r == psp_pkg::OP_EXTEST);
            if (fall && st_r == S_UPDR && ir_r == psp_pkg::OP_EXTEST)
                pin_test_out <= dr_r[BSR_W-1:0];
        end

    // Nonvolatile updates: erase, program, secure, signature
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            nv_wr       <= 1'b0;
            nv_lock_nxt <= 1'b0;
            nv_sig_nxt  <= '0;
            nv_cfg_nxt  <= '0;
        end
        else
        begin
            nv_wr       <= 1'b0;
            nv_lock_nxt <= nv_lock;
            nv_sig_nxt  <= nv_sig;
            nv_cfg_nxt  <= nv_cfg;
            if (fall && prog_r && st_r == S_UPDR)
                case (ir_r)
                    psp_pkg::OP_ERASE:
                    begin
                        nv_wr       <= 1'b1;
                        nv_lock_nxt <= 1'b0;
                        nv_cfg_nxt  <= '0;
                        nv_sig_nxt  <= '0;
                    end
                    psp_pkg::OP_PROGRAM:
                        if (!nv_lock)
                        begin
                            nv_wr      <= 1'b1;
                            nv_cfg_nxt <= dr_r[CFG_W-1:0];
                        end
                    psp_pkg::OP_SECURE:
                    begin
                        nv_wr       <= 1'b1;
                        nv_lock_nxt <= 1'b1;
                    end
                    psp_pkg::OP_PROG_UC:
                    begin
                        nv_wr      <= 1'b1;
                        nv_sig_nxt <= dr_r[31:0];
                    end
                    default:
                        nv_wr <= 1'b0;
                endcase
        end

    // Active image every clk, test data out on tck fall
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            cfg_out  <= '0;
            lock_out <= 1'b0;
            tdo      <= 1'b0;
            tdo_oe   <= 1'b0;
        end
        else
        begin
            cfg_out  <= por_done ? nv_cfg : '0;
            lock_out <= nv_lock;
            if (fall)
            begin
                tdo_oe <= (st_r == S_SHDR) || (st_r == S_SHIR);
                tdo    <= (st_r == S_SHIR) ? ir_sh_r[0] : dr_r[0];
            end
        end
endmodule

// file: tb/psp_asserts.sv
/* Port checker for the configuration loader.
   Assumes one clk domain and an async high rst. */
`timescale 1ns/1ps
module psp_asserts #(
    parameter int CFG_W = 64
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             rst,
    // Scan and status
    input wire logic             tck,
    input wire logic             tdo,
    input wire logic             tdo_oe,
    input wire logic             pin_test_en,
    input wire logic             por_busy,
    input wire logic             pull_up_en,
    input wire logic             reg_q_clr,
    input wire logic             lock_out,
    input wire logic [CFG_W-1:0] cfg_out,
    // Nonvolatile image
    input wire logic             nv_lock,
    input wire logic [CFG_W-1:0] nv_cfg,
    input wire logic             nv_wr,
    input wire logic             nv_lock_nxt,
    input wire logic [31:0]      nv_sig_nxt,
    input wire logic [CFG_W-1:0] nv_cfg_nxt
);
    logic [5:0] por_cnt_r;  // Cycles since reset release
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Count up and saturate
    always_ff @(posedge clk or posedge rst)
        if (rst)
            por_cnt_r <= 6'h00;
        else if (por_cnt_r != 6'h3F)
            por_cnt_r <= por_cnt_r + 6'h01;
    property p_por_hold; (por_cnt_r <= 6'(psp_pkg::POR_CYC)) |-> por_busy; endproperty
    a_por_hold: assert property (p_por_hold) else $error("por_busy fell early");
    property p_por_end; (por_cnt_r > 6'(psp_pkg::POR_CYC)) |-> !por_busy; endproperty
    a_por_end: assert property (p_por_end) else $error("por_busy stuck");
    property p_pull; (pull_up_en == por_busy) && (reg_q_clr == por_busy); endproperty
    a_pull: assert property (p_pull) else $error("pull_up_en or reg_q_clr wrong");
    property p_cfg_zero; por_busy |-> cfg_out == '0; endproperty
    a_cfg_zero: assert property (p_cfg_zero) else $error("cfg_out not low");
    property p_quiet; por_busy |-> !(tdo_oe || nv_wr || pin_test_en); endproperty
    a_quiet: assert property (p_quiet) else $error("port active in power-up");
    property p_wr_pulse; nv_wr |=> !nv_wr; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("nv_wr too long");
    property p_lock_kept; nv_wr && nv_lock && nv_lock_nxt |-> nv_cfg_nxt == nv_cfg; endproperty
    a_lock_kept: assert property (p_lock_kept) else $error("array written while locked");
    property p_erase_only; nv_wr && nv_lock && !nv_lock_nxt |-> (nv_cfg_nxt == '0) && (nv_sig_nxt == '0);
    endproperty
    a_erase_only: assert property (p_erase_only) else $error("lock cleared without erase");
    property p_lock_copy; !por_busy ##1 (!por_busy && $stable(nv_lock)) |-> lock_out == nv_lock; endproperty
    a_lock_copy: assert property (p_lock_copy) else $error("lock_out differs");
    property p_tdo_hold; $rose(tck) |-> ##1 $stable(tdo) [*4]; endproperty
    a_tdo_hold: assert property (p_tdo_hold) else $error("tdo moved after tck rise");
endmodule
bind psp_loader psp_asserts #(.CFG_W(CFG_W)) i_psp_asserts (
    .clk(clk), .rst(rst), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe), .pin_test_en(pin_test_en),
    .por_busy(por_busy), .pull_up_en(pull_up_en), .reg_q_clr(reg_q_clr), .lock_out(lock_out),
    .cfg_out(cfg_out), .nv_lock(nv_lock), .nv_cfg(nv_cfg), .nv_wr(nv_wr),
    .nv_lock_nxt(nv_lock_nxt), .nv_sig_nxt(nv_sig_nxt), .nv_cfg_nxt(nv_cfg_nxt));

// file: tb/psp_host.sv
/* Scan host model driving tck, tms and tdi.
   Assumes the loader samples them with clk. */
`timescale 1ns/1ps
module psp_host (
    // System clock
    input wire logic clk,
    // Scan pins
    input wire logic tdo,
    input wire logic tdo_oe,
    output logic     tck,
    output logic     tms,
    output logic     tdi
);
    // Scan clock static until first frame
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One scan clock: 6 low, 2 high, 320 ns
    task automatic step(input logic m, input logic d, output logic o);
        tms <= m;
        tdi <= d;
        repeat (6) @(posedge clk);
        o = tdo_oe ? tdo : 1'b1; // Released line floats to the pull-up level
        tck <= 1'b1;
        repeat (2) @(posedge clk);
        tck <= 1'b0;
    endtask
    // Idle to IR or DR scan and back to idle, LSB first
    task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
        logic o;
        dout = '0;
        step(1'b0, 1'b0, o);
        step(1'b1, 1'b0, o);
        if (ir)
            step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(n == 0, 1'b0, o);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask
endmodule

// file: tb/tb_top.sv
/* Bench for the loader: power-up, lock, erase, program, scan.
   Assumes psp_host drives the scan pins. */
`timescale 1ns/1ps
module tb_top;
    logic clk, rst, tck, tms, tdi, tdo, tdo_oe, pin_test_en, por_busy, pull_up_en, reg_q_clr;
    logic nv_lock, nv_wr, nv_lock_nxt, lock_out;
    logic [15:0] pin_in, pin_test_out;
    logic [31:0] nv_sig, nv_sig_nxt;
    logic [63:0] nv_cfg, nv_cfg_nxt, cfg_out, d;
    int fails, cmp_count;
    psp_loader i_psp_loader (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_test_out(pin_test_out), .pin_test_en(pin_test_en),
        .por_busy(por_busy), .pull_up_en(pull_up_en), .reg_q_clr(reg_q_clr), .nv_lock(nv_lock),
        .nv_sig(nv_sig), .nv_cfg(nv_cfg), .nv_wr(nv_wr), .nv_lock_nxt(nv_lock_nxt),
        .nv_sig_nxt(nv_sig_nxt), .nv_cfg_nxt(nv_cfg_nxt), .cfg_out(cfg_out), .lock_out(lock_out));
    psp_host i_psp_host (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi));
    always #20 clk = ~clk;
    // Nonvolatile cells take the new image
    always @(posedge clk)
        if (nv_wr)
        begin
            nv_lock <= nv_lock_nxt;
            nv_sig <= nv_sig_nxt;
            nv_cfg <= nv_cfg_nxt;
        end
    task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
        cmp_count++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic ir(input logic [7:0] op);
        i_psp_host.scan(1'b1, 8, {56'h0, op}, d);
    endtask
    task automatic dr(input int n, input logic [63:0] v);
        i_psp_host.scan(1'b0, n, v, d);
    endtask
    // Power-up state, then release
    task automatic t_por;
        chk("por_busy", por_busy, 1);
        chk("pull_up_en", pull_up_en, 1);
        chk("cfg_out", cfg_out, 0);
        repeat (30) @(posedge clk);
        #1;
        chk("por_busy", por_busy, 0);
        chk("cfg_out", cfg_out, nv_cfg);
        @(posedge clk);
    endtask
    // Locked part: signature readable, array hidden and frozen
    task automatic t_locked;
        ir(psp_pkg::OP_SCAN_USER_CODE);
        chk("ir_capture", d[7:0], psp_pkg::IR_CAPTURE);
        dr(32, 0);
        chk("user_code", d[31:0], nv_sig);
        ir(psp_pkg::OP_PROG_EN);
        ir(psp_pkg::OP_READ);
        dr(64, 0);
        chk("read_locked", d, 0);
        ir(psp_pkg::OP_PROGRAM);
        dr(64, 64'h5555_AAAA_0F0F_F0F0);
        chk("nv_cfg", nv_cfg, 64'h0123_4567_89AB_CDEF);
        ir(psp_pkg::OP_SECURE);
        dr(0, 0);
        chk("nv_lock", nv_lock, 1);
        chk("lock_out", lock_out, 1);
    endtask
    // Erase, program, read back, relock
    task automatic t_prog;
        ir(psp_pkg::OP_ERASE);
        dr(0, 0);
        chk("nv_lock", nv_lock, 0);
        ir(psp_pkg::OP_PROGRAM);
        dr(64, 64'h5555_AAAA_0F0F_F0F0);
        chk("nv_cfg", nv_cfg, 64'h5555_AAAA_0F0F_F0F0);
        ir(psp_pkg::OP_READ);
        dr(64, 0);
        chk("readback", d, 64'h5555_AAAA_0F0F_F0F0);
        ir(psp_pkg::OP_PROG_UC);
        dr(32, 64'h0000_0000_9E3C_71A5);
        ir(psp_pkg::OP_SECURE);
        dr(0, 0);
        chk("nv_lock", nv_lock, 1);
        ir(psp_pkg::OP_READ);
        dr(64, 0);
        chk("read_secured", d, 0);
        ir(psp_pkg::OP_SCAN_USER_CODE);
        dr(32, 0);
        chk("user_code", d[31:0], 32'h9E3C_71A5);
        ir(psp_pkg::OP_PROG_DIS);
    endtask
    // Boundary cells capture, apply and bypass
    task automatic t_bscan;
        pin_in <= 16'hA5C3;
        ir(psp_pkg::OP_SAMPLE);
        dr(16, 0);
        chk("sample", d[15:0], 16'hA5C3);
        ir(psp_pkg::OP_EXTEST);
        dr(16, 64'h3C5A);
        chk("pin_test_out", pin_test_out, 16'h3C5A);
        chk("pin_test_en", pin_test_en, 1);
        ir(psp_pkg::OP_BYPASS);
        dr(2, 1);
        chk("bypass", d[1:0], 2'b10);
        chk("pin_test_en", pin_test_en, 0);
        repeat (5) i_psp_host.step(1'b1, 1'b0, d[0]);
        dr(32, 0);
        chk("idcode", d[31:0], psp_pkg::IDCODE_VAL);
    endtask
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        pin_in = 16'h0000;
        nv_lock = 1'b1;
        nv_sig = 32'hC0DE_5A17;
        nv_cfg = 64'h0123_4567_89AB_CDEF;
        fails = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_por();
        t_locked();
        t_prog();
        t_bscan();
        print_verdict();
    end
    // Hang guard
    initial
    begin
        repeat (60000) @(posedge clk);
        fails++;
        print_verdict();
    end
endmodule
